// [src/acpc_consts.svh]
// Functional notes
// - a falling edge on conversion_start_n alone launches a conversion.
// - while converting, further start edges and power-down are ignored until done.
// - start handling does not look at chip select or read enable.
// - power-down high enters minimum current only after any conversion ends.
// - the digital interface stays enabled while powered down.
// - a configuration bit can request power-down, and then the pin is ignored.
// - in low-power mode high-current circuits turn off after each conversion.
// - in low-power mode the digital interface keeps running during acquisition.
// - both reference power-down inputs low enable reference, buffer and sensor.
// - reference power-down high, buffer low keeps only the buffer enabled.
// - both reference power-down inputs high disable reference and buffer.
// - fastest-mode select low with low-power select high picks low-power mode.
// - a rising edge on the reset input aborts conversion and floats the bus.
`ifndef ACPC_CONSTS_SVH
`define ACPC_CONSTS_SVH

`define ACPC_CLK_HZ 10000000
// conversion time in ns, and a cycle count derived from it (rounded down)
`define ACPC_CONV_NS 1000
`define ACPC_CONV_CYC ((`ACPC_CONV_NS * (`ACPC_CLK_HZ / 1000000)) / 1000)
`define ACPC_CNT_W 8
`define ACPC_SYNC_STAGES 3
// synchroniser reset levels in pin order; only the start pin idles high
`define ACPC_SYNC_IDLE 7'h40

`endif

// [src/acpc_pkg.sv]
package acpc_pkg;
   typedef enum logic [1:0] {ACPC_IDLE, ACPC_CONV, ACPC_DOWN} acpc_state_t;
endpackage

// [src/acpc_sync.sv]
`timescale 1ns/1ps
`include "acpc_consts.svh"
// three-stage synchroniser; a change counts once stages two and three agree
module acpc_sync
(
   input wire logic clk_i, // clock
   input wire logic rst_i, // sync reset
   input wire logic rst_val_i, // level loaded during reset
   input wire logic d_i, // async input
   output logic q_o // filtered level
);
   logic [2:0] sh_reg;
   logic [2:0] sh_next;
   logic q_reg;
   logic q_next;

   always_comb
   begin
      sh_next = {sh_reg[1:0], d_i};
      q_next = q_reg;
      if (sh_reg[1] == sh_reg[2])
      begin
         q_next = sh_reg[2];
      end
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         sh_reg <= {3{rst_val_i}};
         q_reg <= rst_val_i;
      end
      else
      begin
         sh_reg <= sh_next;
         q_reg <= q_next;
      end
   end

   assign q_o = q_reg;
endmodule

// [src/acpc_top.sv]
`timescale 1ns/1ps
`include "acpc_consts.svh"
module acpc_top
   import acpc_pkg::*;
#(
   parameter int CONV_CYCLES = `ACPC_CONV_CYC
)
(
   input wire logic clk_i, // 10 MHz clock
   input wire logic rst_i, // synchronous reset
   input wire logic conversion_start_n_i, // start pin, falling edge
   input wire logic power_down_pin_i, // power-down pin
   input wire logic cfg_power_down_i, // register power-down value
   input wire logic cfg_use_reg_i, // register path selected
   input wire logic fast_mode_sel_i, // fastest-mode select pin
   input wire logic low_power_sel_i, // low-power select pin
   input wire logic ref_powerdown_i, // reference power-down pin
   input wire logic refbuf_powerdown_i, // buffer power-down pin
   input wire logic reset_pin_i, // device reset pin
   input wire logic cs_n_i, // chip select (not used by start)
   input wire logic rd_n_i, // read enable (not used by start)
   output logic busy_o, // conversion in progress
   output logic conv_done_o, // one-cycle result complete
   output logic powered_down_o, // minimum-current state
   output logic hi_current_en_o, // high-current circuits on
   output logic low_power_mode_o, // low-power mode selected
   output logic digital_if_en_o, // digital interface running
   output logic bus_float_o, // data bus held high impedance
   output logic bandgap_en_o, // internal reference on
   output logic refbuf_en_o, // reference buffer on
   output logic temp_sensor_en_o // temperature sensor on
);
   // ***************************************
   // elaboration checks
   // ***************************************
   if (CONV_CYCLES < 1 || CONV_CYCLES >= (1 << `ACPC_CNT_W))
   begin : g_bad
      $error("CONV_CYCLES out of range");
   end

   // ***************************************
   // pin synchronisers
   // ***************************************
   logic start_n_s;
   logic pd_s;
   logic fast_s;
   logic lp_s;
   logic ref_powerdown_s;
   logic refbuf_powerdown_s;
   logic rstpin_s;
   logic [6:0] raw;
   logic [6:0] syn;
   localparam logic [6:0] SYNC_IDLE = `ACPC_SYNC_IDLE;

   assign raw = {conversion_start_n_i, power_down_pin_i, fast_mode_sel_i,
                 low_power_sel_i, ref_powerdown_i, refbuf_powerdown_i,
                 reset_pin_i};

   for (genvar i = 0; i < 7; i++)
   begin : g_sync
      acpc_sync u_sync
      (
         .clk_i(clk_i),
         .rst_i(rst_i),
         .rst_val_i(SYNC_IDLE[i]),
         .d_i(raw[i]),
         .q_o(syn[i])
      );
   end

   assign {start_n_s, pd_s, fast_s, lp_s, ref_powerdown_s, refbuf_powerdown_s, rstpin_s} = syn;

   // ***************************************
   // conversion control
   // ***************************************
   acpc_state_t state_reg;
   acpc_state_t state_next;
   logic [`ACPC_CNT_W-1:0] cnt_reg;
   logic [`ACPC_CNT_W-1:0] cnt_next;
   logic start_d_reg;
   logic start_d_next;
   logic rstpin_d_reg;
   logic rstpin_d_next;
   logic float_reg;
   logic float_next;
   logic done_reg;
   logic done_next;
   logic start_fall;
   logic rst_rise;
   logic pd_req;
   logic lp_mode;

   // start_d resets low, yet a pin held low through reset reads as an edge once its synchroniser settles
   assign start_fall = start_d_reg & ~start_n_s;
   assign rst_rise = rstpin_s & ~rstpin_d_reg;
   assign pd_req = cfg_use_reg_i ? cfg_power_down_i : pd_s;
   assign lp_mode = ~fast_s & lp_s;

   always_comb
   begin
      state_next = state_reg;
      cnt_next = cnt_reg;
      start_d_next = start_n_s;
      rstpin_d_next = rstpin_s;
      float_next = float_reg;
      done_next = 1'b0;
      if (rst_rise)
      begin
         // abort wins over everything else
         state_next = ACPC_IDLE;
         cnt_next = '0;
         float_next = 1'b1;
      end
      else
      begin
         if (!rstpin_s)
         begin
            float_next = 1'b0;
         end
         case (state_reg)
            ACPC_IDLE:
            begin
               if (start_fall && !rstpin_s)
               begin
                  state_next = ACPC_CONV;
                  cnt_next = CONV_CYCLES[`ACPC_CNT_W-1:0] - 8'h01;
               end
               else if (pd_req)
               begin
                  state_next = ACPC_DOWN;
               end
            end
            ACPC_CONV:
            begin
               // start edges are not looked at here; power-down only when the count reaches zero
               if (cnt_reg == '0)
               begin
                  done_next = 1'b1;
                  state_next = pd_req ? ACPC_DOWN : ACPC_IDLE;
               end
               else
               begin
                  cnt_next = cnt_reg - 8'h01;
               end
            end
            ACPC_DOWN:
            begin
               if (start_fall && !rstpin_s)
               begin
                  state_next = ACPC_CONV;
                  cnt_next = CONV_CYCLES[`ACPC_CNT_W-1:0] - 8'h01;
               end
               else if (!pd_req)
               begin
                  state_next = ACPC_IDLE;
               end
            end
            default:
            begin
               state_next = ACPC_IDLE;
            end
         endcase
      end
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         state_reg <= ACPC_IDLE;
         cnt_reg <= '0;
         start_d_reg <= 1'b0;
         rstpin_d_reg <= 1'b0;
         float_reg <= 1'b1;
         done_reg <= 1'b0;
      end
      else
      begin
         state_reg <= state_next;
         cnt_reg <= cnt_next;
         start_d_reg <= start_d_next;
         rstpin_d_reg <= rstpin_d_next;
         float_reg <= float_next;
         done_reg <= done_next;
      end
   end

   // ***************************************
   // status and power outputs
   // ***************************************
   logic conv;
   assign conv = (state_reg == ACPC_CONV);

   assign busy_o = conv;
   assign conv_done_o = done_reg;
   assign powered_down_o = (state_reg == ACPC_DOWN);
   // low-power mode only drops analog power outside conversion
   assign hi_current_en_o = conv | (~lp_mode & ~powered_down_o);
   assign low_power_mode_o = lp_mode;
   // digital side never gated, even in power-down or acquisition
   assign digital_if_en_o = 1'b1;
   assign bus_float_o = float_reg | rstpin_s;

   // ***************************************
   // reference decode
   // ***************************************
   // registered so the enables leave the block glitch-free
   logic bandgap_reg;
   logic bandgap_next;
   logic refbuf_reg;
   logic refbuf_next;
   logic temp_reg;
   logic temp_next;

   always_comb
   begin
      bandgap_next = ~ref_powerdown_s & ~refbuf_powerdown_s;
      refbuf_next = ~refbuf_powerdown_s;
      temp_next = ~ref_powerdown_s & ~refbuf_powerdown_s;
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         bandgap_reg <= 1'b0;
         refbuf_reg <= 1'b0;
         temp_reg <= 1'b0;
      end
      else
      begin
         bandgap_reg <= bandgap_next;
         refbuf_reg <= refbuf_next;
         temp_reg <= temp_next;
      end
   end

   assign bandgap_en_o = bandgap_reg;
   assign refbuf_en_o = refbuf_reg;
   assign temp_sensor_en_o = temp_reg;
endmodule

// [verification/acpc_host.sv]
`timescale 1ns/1ps
module acpc_host
(
   input wire logic clk_i, // clock
   input wire logic go_i, // request one start pulse
   output logic start_n_o // start pin
);
   int low_cnt = 0;
   initial start_n_o = 1'b1;
   // low for four cycles so the three-stage synchroniser sees it
   always @(negedge clk_i)
   begin
      if (go_i)
         low_cnt = 4;
      start_n_o <= (low_cnt == 0);
      if (low_cnt > 0)
         low_cnt = low_cnt - 1;
   end
endmodule

// [verification/acpc_top_chk.sv]
`timescale 1ns/1ps
module acpc_chk #(parameter int CONV_CYCLES = 10)
(
   input wire logic clk_i, // clock
   input wire logic rst_i, // reset
   input wire logic reset_pin_i, // abort pin
   input wire logic busy_o, // busy
   input wire logic conv_done_o, // done
   input wire logic powered_down_o, // down
   input wire logic hi_current_en_o, // power
   input wire logic low_power_mode_o, // mode
   input wire logic digital_if_en_o, // interface
   input wire logic bus_float_o, // float
   input wire logic bandgap_en_o, // reference
   input wire logic refbuf_en_o, // buffer
   input wire logic temp_sensor_en_o // sensor
);
   logic [7:0] run_reg, run_next;
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   always_comb run_next = busy_o ? run_reg + 8'h01 : 8'h00;
   always_ff @(posedge clk_i) run_reg <= rst_i ? 8'h00 : run_next;
   property p_len; $fell(busy_o) && !reset_pin_i |-> run_reg == CONV_CYCLES;
   endproperty
   a_len: assert property (p_len) else $error("busy length");
   property p_done; conv_done_o |=> !conv_done_o; endproperty
   a_done: assert property (p_done) else $error("done width");
   property p_down; powered_down_o |-> !busy_o; endproperty
   a_down: assert property (p_down) else $error("down while busy");
   property p_hic; busy_o |-> hi_current_en_o; endproperty
   a_hic: assert property (p_hic) else $error("power off busy");
   property p_lp;
      $fell(busy_o) && low_power_mode_o |-> ##[0:1] !hi_current_en_o;
   endproperty
   a_lp: assert property (p_lp) else $error("lp power");
   property p_dig; digital_if_en_o; endproperty
   a_dig: assert property (p_dig) else $error("if off");
   property p_ts; temp_sensor_en_o == bandgap_en_o; endproperty
   a_ts: assert property (p_ts) else $error("sensor");
   property p_ref; bandgap_en_o |-> refbuf_en_o; endproperty
   a_ref: assert property (p_ref) else $error("buffer");
   property p_abort; $rose(reset_pin_i) |-> ##[1:6] (!busy_o && bus_float_o);
   endproperty
   a_abort: assert property (p_abort) else $error("abort");
   property p_noabort;
      $fell(busy_o) |-> conv_done_o || bus_float_o;
   endproperty
   a_noabort: assert property (p_noabort) else $error("cut short");
endmodule

bind acpc_top acpc_chk #(.CONV_CYCLES(CONV_CYCLES)) chk (.clk_i(clk_i),
   .rst_i(rst_i), .reset_pin_i(reset_pin_i), .busy_o(busy_o),
   .conv_done_o(conv_done_o), .powered_down_o(powered_down_o),
   .hi_current_en_o(hi_current_en_o), .low_power_mode_o(low_power_mode_o),
   .digital_if_en_o(digital_if_en_o), .bus_float_o(bus_float_o),
   .bandgap_en_o(bandgap_en_o), .refbuf_en_o(refbuf_en_o),
   .temp_sensor_en_o(temp_sensor_en_o));

// [verification/acpc_top_tb.sv]
`timescale 1ns/1ps
module acpc_top_tb;
   localparam int CONV = 12;
   logic clk_i = 1'b0, rst_i = 1'b1, go = 1'b0, sn, pd = 1'b0, cpd = 1'b0;
   logic creg = 1'b0, fast = 1'b1, lp = 1'b0, rref = 1'b0, rbuf = 1'b0;
   logic rpin = 1'b0, cs_n = 1'b0, rd_n = 1'b0, dn;
   logic busy, done, down, hic, lpm, dig, flt, bg, rb, ts;
   int fails = 0, samples_checked = 0, cyc = 0, seed = 32'h7c3ad5b6, n, i;
   // model: one expected conversion length per accepted start
   int exp_q[$];
   acpc_host host (.clk_i(clk_i), .go_i(go), .start_n_o(sn));
   acpc_top #(.CONV_CYCLES(CONV)) dut (.clk_i(clk_i), .rst_i(rst_i),
      .conversion_start_n_i(sn), .power_down_pin_i(pd),
      .cfg_power_down_i(cpd), .cfg_use_reg_i(creg), .fast_mode_sel_i(fast),
      .low_power_sel_i(lp), .ref_powerdown_i(rref),
      .refbuf_powerdown_i(rbuf), .reset_pin_i(rpin), .cs_n_i(cs_n),
      .rd_n_i(rd_n), .busy_o(busy), .conv_done_o(done),
      .powered_down_o(down), .hi_current_en_o(hic),
      .low_power_mode_o(lpm), .digital_if_en_o(dig), .bus_float_o(flt),
      .bandgap_en_o(bg), .refbuf_en_o(rb), .temp_sensor_en_o(ts));
   initial forever #50 clk_i = ~clk_i;
   // chip select and read enable wander at random; start must not care
   always @(negedge clk_i) {cs_n, rd_n} <= 2'($random(seed));
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      samples_checked++;
      if (got !== exp)
      begin
         fails++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic print_verdict;
      if (fails == 0 && samples_checked > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   always @(posedge clk_i)
   begin
      cyc++;
      if (cyc == 3000)
      begin
         fails++;
         print_verdict;
      end
   end
   task automatic conv(input bit twice);
      repeat (4) @(negedge clk_i);
      go <= 1'b1;
      @(negedge clk_i);
      go <= 1'b0;
      exp_q.push_back(CONV);
      repeat (20)
         if (busy !== 1'b1)
            @(negedge clk_i);
      chk(busy, 1);
      n = 0;
      // a second start edge lands well inside the conversion
      if (twice)
      begin
         repeat (2) @(negedge clk_i);
         go <= 1'b1;
         @(negedge clk_i);
         go <= 1'b0;
         n = 3;
      end
      while (busy === 1'b1 && n < 40)
      begin
         @(negedge clk_i);
         n++;
      end
      dn = done;
      @(negedge clk_i);
      chk(n, exp_q.pop_front());
      chk(dn | done, 1);
   endtask
   initial
   begin
      repeat (20) @(negedge clk_i);
      rst_i = 1'b0;
      conv(1'b0);
      conv(1'b1);
      fork
         conv(1'b0);
         begin
            repeat (10) @(negedge clk_i);
            pd = 1'b1;
         end
      join
      repeat (2) @(negedge clk_i);
      chk({down, dig}, 2'b11);
      for (i = 0; i < 8; i++)
      begin
         {creg, cpd, pd} = 3'(i);
         repeat (5) @(negedge clk_i);
         chk(down, creg ? cpd : pd);
      end
      // leave power-down so the power outputs show the mode alone
      {creg, cpd, pd} = 3'h0;
      for (i = 0; i < 4; i++)
      begin
         {rref, rbuf, fast, lp} = {2'(i), ~2'(i)};
         repeat (5) @(negedge clk_i);
         chk({bg, rb, ts}, {!i, !rbuf, !i});
         chk({lpm, hic}, {!fast && lp, !(!fast && lp)});
      end
      {fast, lp} = 2'b01;
      conv(1'b0);
      chk({hic, dig}, 2'b01);
      go <= 1'b1;
      repeat (8) @(negedge clk_i);
      go <= 1'b0;
      rpin = 1'b1;
      repeat (7) @(negedge clk_i);
      chk({busy, flt}, 2'b01);
      rpin = 1'b0;
      print_verdict;
   end
endmodule
